// file: adcc_pkg.sv
// What this block does
// - conversion-active falling at completion sets the conversion-end request flag
// - interrupt request raised only while the conversion-end enable bit is one
// - three-bit channel field picks analog channel by binary value; 001 is one
// - each pin analog select bit marks its own pin analog when set
// - writing zero clears the request flag; software clears it before enabling
// - writing one to conversion-active flag starts conversion on selected channel
// - completion loads result, clears active flag same cycle, returns to idle
// - another write of one after idle starts a fresh full conversion
// - speed bit zero gives 62 clock cycles, one gives 31 cycles
// - 8-bit result held until next completion and not cleared on reset
// - writing zero to the active flag during conversion stops it
package adcc_pkg;

	localparam int RES_BITS = 8;
	localparam int CHAN_BITS = 3;
	localparam int NUM_CHAN = 8;
	localparam int CONV_SLOW_CYC = 62;
	localparam int CONV_FAST_CYC = 31;
	localparam int STEPS = RES_BITS;

	localparam int MODE_SPEED_POS = 7;
	localparam int MODE_CHAN_POS = 0;
	localparam logic [3:0] MODE_RSVD_VAL = 4'hf;
	localparam logic [7:0] MODE_RST = 8'h78;
	localparam logic [7:0] START_RSVD_VAL = 8'h7f;
	localparam logic [7:0] PIN_SEL_RST = 8'h00;
	localparam logic [7:0] SAR_FIRST = 8'h80;
	localparam logic [7:0] CHAN_ONE_HOT = 8'h01;

	typedef struct packed {
		logic speed;
		logic [3:0] rsvd;
		logic [2:0] chan;
	} adcc_mode_t;

	typedef struct packed {
		logic [7:0] mux_sel;
		logic [7:0] dac_code;
		logic sample;
	} adcc_afe_t;

endpackage

// file: adcc_sar.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_sar #(
	parameter int WIDTH = adcc_pkg::RES_BITS
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic decide_i,
	input wire logic cmp_i,
	output logic [WIDTH-1:0] code_o,
	output logic [WIDTH-1:0] next_code_o
);
	import adcc_pkg::*;

	if (WIDTH < 2) begin : g_bad_width
		$error("sar width must be at least two bits");
	end

	logic [WIDTH-1:0] mask;
	logic [WIDTH-1:0] next_trial;

	// keep the trial bit only when the input is at or above it
	assign next_code_o = cmp_i ? code_o : (code_o & ~mask);
	assign next_trial = next_code_o | (mask >> 1);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			code_o <= '0;
			mask <= '0;
		end else if (load_i) begin
			code_o <= {1'b1, {(WIDTH-1){1'b0}}};
			mask <= {1'b1, {(WIDTH-1){1'b0}}};
		end else if (decide_i) begin
			code_o <= next_trial;
			mask <= mask >> 1;
		end
	end

endmodule
`default_nettype wire

// file: adcc_conv_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_conv_ctrl #(
	parameter int SLOW_CYCLES = adcc_pkg::CONV_SLOW_CYC,
	parameter int FAST_CYCLES = adcc_pkg::CONV_FAST_CYC
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic mode_wr_i,
	input wire adcc_pkg::adcc_mode_t mode_wdata_i,
	input wire logic start_wr_i,
	input wire logic start_wdata_i,
	input wire logic req_wr_i,
	input wire logic req_wdata_i,
	input wire logic conv_end_irq_enable_i,
	input wire logic pin_sel_wr_i,
	input wire logic [7:0] pin_sel_wdata_i,
	input wire logic analog_cmp_i,
	output var adcc_pkg::adcc_mode_t converter_mode_reg_o,
	output logic [7:0] pin_analog_select_bits_o,
	output logic conversion_active_flag_o,
	output logic [7:0] converter_start_reg_o,
	output logic conv_end_request_flag_o,
	output logic conv_end_irq_o,
	output logic [7:0] conversion_result_reg_o,
	output var adcc_pkg::adcc_afe_t afe_o
);
	import adcc_pkg::*;

	if (SLOW_CYCLES < 8 || SLOW_CYCLES > 63 ||
		FAST_CYCLES < 8 || FAST_CYCLES > 63) begin : g_bad_period
		$error("conversion periods must lie between 8 and 63 cycles");
	end

	////////////////////////////////////////////////////////////////////////
	// period and step timing
	localparam logic [5:0] SLOW_M1 = 6'(SLOW_CYCLES - 1);
	localparam logic [5:0] FAST_M1 = 6'(FAST_CYCLES - 1);
	localparam logic [2:0] SLOW_STEP_M1 = 3'(SLOW_CYCLES / STEPS - 1);
	localparam logic [2:0] FAST_STEP_M1 = 3'(FAST_CYCLES / STEPS - 1);
	localparam logic [5:0] SLOW_SAMP =
		6'(SLOW_CYCLES - STEPS * (SLOW_CYCLES / STEPS));
	localparam logic [5:0] FAST_SAMP =
		6'(FAST_CYCLES - STEPS * (FAST_CYCLES / STEPS));
	localparam logic [6:0] SLOW_LEN = 7'(SLOW_CYCLES);
	localparam logic [6:0] FAST_LEN = 7'(FAST_CYCLES);

	logic active;
	logic run_fast;
	logic [5:0] cyc;
	logic [2:0] tick;
	logic req;
	logic irq;
	adcc_mode_t mode;
	logic [7:0] pin_sel;
	logic [7:0] mux_sel;
	logic [7:0] result;
	logic sample;
	logic [6:0] run_len;
	logic loaded;

	logic [7:0] dac_code;
	logic [7:0] sar_result;

	////////////////////////////////////////////////////////////////////////
	// decode
	wire start_req = start_wr_i && start_wdata_i && !active;
	wire stop_req = start_wr_i && !start_wdata_i && active;
	wire [5:0] period_m1 = run_fast ? FAST_M1 : SLOW_M1;
	wire [2:0] step_m1 = run_fast ? FAST_STEP_M1 : SLOW_STEP_M1;
	wire [5:0] samp_len = run_fast ? FAST_SAMP : SLOW_SAMP;
	wire in_sample = cyc < samp_len;
	wire decide = active && !in_sample && (tick == step_m1);
	wire finish = active && (cyc == period_m1) && !stop_req;
	wire req_clr = req_wr_i && !req_wdata_i;
	// a completion in the clearing cycle still sets the flag
	wire next_req = finish || (req && !req_clr);
	wire next_active = start_req || (active && !finish && !stop_req);
	wire next_irq = next_req && conv_end_irq_enable_i;
	wire adcc_mode_t next_mode = mode_wr_i ?
		{mode_wdata_i.speed, MODE_RSVD_VAL, mode_wdata_i.chan} : mode;
	wire [7:0] next_mux_sel = CHAN_ONE_HOT << next_mode.chan;
	wire [7:0] next_pin_sel = pin_sel_wr_i ? pin_sel_wdata_i : pin_sel;

	////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode <= MODE_RST;
			mux_sel <= CHAN_ONE_HOT;
			pin_sel <= PIN_SEL_RST;
		end else begin
			mode <= next_mode;
			mux_sel <= next_mux_sel;
			pin_sel <= next_pin_sel;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active <= 1'b0;
			req <= 1'b0;
			irq <= 1'b0;
			sample <= 1'b0;
		end else begin
			active <= next_active;
			req <= next_req;
			irq <= next_irq;
			sample <= active && in_sample && next_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencing
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_fast <= 1'b0;
			cyc <= '0;
		end else if (start_req) begin
			run_fast <= mode.speed;
			cyc <= '0;
		end else if (active) begin
			cyc <= cyc + 6'h01;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick <= '0;
		end else if (start_req || decide) begin
			tick <= '0;
		end else if (active && !in_sample) begin
			tick <= tick + 3'h1;
		end
	end

	// result has no reset and changes only on completion
	always_ff @(posedge clock_i) begin
		if (finish) begin
			result <= sar_result;
		end
	end

	adcc_sar #(
		.WIDTH(RES_BITS)
	) u_sar (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.load_i(start_req),
		.decide_i(decide),
		.cmp_i(analog_cmp_i),
		.code_o(dac_code),
		.next_code_o(sar_result)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign converter_mode_reg_o = mode;
	assign pin_analog_select_bits_o = pin_sel;
	assign conversion_active_flag_o = active;
	assign converter_start_reg_o = {active, START_RSVD_VAL[6:0]};
	assign conv_end_request_flag_o = req;
	assign conv_end_irq_o = irq;
	assign conversion_result_reg_o = result;
	assign afe_o = '{mux_sel: mux_sel, dac_code: dac_code, sample: sample};

	////////////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_len <= '0;
		end else if (start_req) begin
			run_len <= 7'h01;
		end else if (active) begin
			run_len <= run_len + 7'h01;
		end
	end

	// result is unknown until the first completion
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			loaded <= 1'b0;
		end else if (finish) begin
			loaded <= 1'b1;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_start;
		start_wr_i && start_wdata_i && !active;
	endsequence

	sequence s_finish;
		active && (cyc == period_m1) && !(start_wr_i && !start_wdata_i);
	endsequence

	chk_end_sets_req: assert property (
		s_finish |=> req && !active && $fell(active))
		else $error("completion did not raise the request flag");

	chk_irq_gated: assert property (
		irq |-> req && $past(conv_end_irq_enable_i))
		else $error("interrupt raised without enable or request");

	chk_irq_follows: assert property (
		req && conv_end_irq_enable_i && !req_wr_i |=> irq)
		else $error("enabled request gave no interrupt");

	chk_chan_decode: assert property (
		mode_wr_i && mode_wdata_i.chan == 3'h1 |=> mux_sel == 8'h02)
		else $error("channel pattern 001 did not select channel one");

	chk_pin_select: assert property (
		pin_sel_wr_i |=> pin_sel == $past(pin_sel_wdata_i))
		else $error("pin analog select bits not stored");

	chk_req_clear: assert property (
		req_wr_i && !req_wdata_i && !finish |=> !req)
		else $error("writing zero did not clear the request flag");

	chk_start_conv: assert property (
		s_start |=> active && dac_code == SAR_FIRST && cyc == 6'h00)
		else $error("start write did not begin a conversion");

	chk_result_load: assert property (
		s_finish |=> result == $past(sar_result) && !active)
		else $error("result not loaded at completion");

	chk_restart_conv: assert property (
		s_finish ##1 s_start |=>
			active && cyc == 6'h00 && dac_code == SAR_FIRST)
		else $error("conversion after idle did not start");

	chk_period_len: assert property (
		s_finish |-> run_len == (run_fast ? FAST_LEN : SLOW_LEN))
		else $error("conversion period length wrong");

	chk_result_hold: assert property (
		loaded && !finish |=> $stable(result))
		else $error("result changed outside completion");

	chk_stop_conv: assert property (
		active && start_wr_i && !start_wdata_i && !req_wr_i |=>
			!active && req == $past(req))
		else $error("stop write did not halt the conversion");

	chk_msb_first: assert property (
		decide && dac_code == SAR_FIRST |=>
			dac_code == {$past(analog_cmp_i), 7'h40})
		else $error("approximation did not begin at the top bit");

endmodule
`default_nettype wire

// file: adcc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_analog_model (
	input wire adcc_pkg::adcc_afe_t afe_i,
	input wire logic [7:0] pin_sel_i,
	input wire logic [63:0] levels_i,
	output logic cmp_o
);
	import adcc_pkg::*;
	logic [7:0] lvl;
	logic analog;
	always_comb begin
		lvl = 8'h00;
		analog = 1'b0;
		for (int c = 0; c < 8; c++) begin
			if (afe_i.mux_sel[c]) begin
				lvl = levels_i[c*8 +: 8];
				analog = pin_sel_i[c];
			end
		end
	end
	// pin left digital gives a moving pattern
	assign cmp_o = analog ? (lvl >= afe_i.dac_code) : afe_i.dac_code[0];
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import adcc_pkg::*;
	logic clk = 0;
	logic rst_n;
	logic mw, pw, sw, rw, ien, cmp;
	logic st_d, rq_d, act, req, irq;
	adcc_mode_t mode_d, mode_rd;
	adcc_afe_t afe;
	logic [7:0] pin_d, pin_rd, start_rd, res;
	logic [63:0] levels = 64'hff_00_a5_5a_3c_c3_96_69;
	int bad_count = 0;
	int checked = 0;
	always #5 clk = ~clk;
	adcc_conv_ctrl i_adcc_conv_ctrl (.clock_i(clk), .rst_n_i(rst_n),
		.mode_wr_i(mw), .mode_wdata_i(mode_d), .start_wr_i(sw),
		.start_wdata_i(st_d), .req_wr_i(rw), .req_wdata_i(rq_d),
		.conv_end_irq_enable_i(ien), .pin_sel_wr_i(pw),
		.pin_sel_wdata_i(pin_d), .analog_cmp_i(cmp),
		.converter_mode_reg_o(mode_rd), .pin_analog_select_bits_o(pin_rd),
		.conversion_active_flag_o(act), .converter_start_reg_o(start_rd),
		.conv_end_request_flag_o(req), .conv_end_irq_o(irq),
		.conversion_result_reg_o(res), .afe_o(afe));
	adcc_analog_model i_adcc_analog_model (.afe_i(afe), .pin_sel_i(pin_rd),
		.levels_i(levels), .cmp_o(cmp));
	////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task check(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// k: 0 mode, 1 pin, 2 start, 3 request flag
	task wr(input int k, input logic [7:0] d);
		@(negedge clk);
		mode_d = d;
		pin_d = d;
		st_d = d[0];
		rq_d = d[0];
		{mw, pw, sw, rw} = 4'b1000 >> k;
		@(negedge clk);
		{mw, pw, sw, rw} = 4'h0;
	endtask
	task wait_idle(input int p);
		int n;
		n = 0;
		while (act === 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n >= 200) begin
			bad_count++;
			wrap_up;
		end
		check(n[15:0], p[15:0]);
	endtask
	task conv(input int p, input logic [7:0] e, input logic ie);
		wr(2, 8'h01);
		check(act, 1'b1);
		check(start_rd, 8'hff);
		check(afe.dac_code, SAR_FIRST);
		@(negedge clk);
		check(afe.sample, 1'b1);
		wait_idle(p - 1);
		check(start_rd, 8'h7f);
		check(res, e);
		check(req, 1'b1);
		check(irq, ie);
	endtask
	////////////////////////////////////////////////////////////////////
	task sc_typical;
		wr(0, 8'h81);
		check(mode_rd, 8'hf9);
		check(afe.mux_sel, 8'h02);
		wr(1, 8'h02);
		check(pin_rd, 8'h02);
		wr(3, 8'h00);
		check(req, 1'b0);
		ien = 1'b1;
		conv(31, 8'h96, 1'b1);
		wr(3, 8'h01);
		check(req, 1'b1);
		wr(3, 8'h00);
		check(req, 1'b0);
		check(irq, 1'b0);
	endtask
	task sc_slow;
		ien = 1'b0;
		wr(0, 8'h01);
		check(mode_rd, 8'h79);
		conv(62, 8'h96, 1'b0);
		wr(3, 8'h00);
	endtask
	task sc_stop;
		wr(0, 8'h81);
		wr(2, 8'h01);
		repeat (5) @(negedge clk);
		wr(2, 8'h00);
		check(act, 1'b0);
		repeat (40) @(negedge clk);
		check(req, 1'b0);
		check(res, 8'h96);
	endtask
	task sc_back;
		wr(2, 8'h01);
		wait_idle(31);
		sw = 1'b1;
		st_d = 1'b1;
		@(negedge clk);
		sw = 1'b0;
		check(act, 1'b1);
		check(req, 1'b1);
		wait_idle(31);
		check(res, 8'h96);
		wr(3, 8'h00);
	endtask
	task sc_chan;
		for (int c = 0; c < 8; c++) begin
			wr(0, 8'h80 | c[7:0]);
			wr(1, 8'h01 << c);
			check(afe.mux_sel, 8'h01 << c);
			conv(31, levels[c*8 +: 8], 1'b0);
			wr(3, 8'h00);
		end
	endtask
	task sc_reset;
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		check(res, 8'hff);
		check(act, 1'b0);
		check(mode_rd, 8'h78);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		{mw, pw, sw, rw, ien, st_d, rq_d} = 7'h00;
		mode_d = 8'h00;
		pin_d = 8'h00;
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		check(mode_rd, 8'h78);
		check(pin_rd, 8'h00);
		check(start_rd, 8'h7f);
		check({act, req, irq}, 3'b000);
		check(afe.mux_sel, 8'h01);
		sc_typical;
		sc_slow;
		sc_stop;
		sc_back;
		sc_chan;
		sc_reset;
		wrap_up;
	end
endmodule
`default_nettype wire
